// File: design/mmrb_defines.vh
// constants for the memory-mapped register bank: offsets, widths, timing
// assumes inclusion by the bank module only
`ifndef MMRB_DEFINES_VH
`define MMRB_DEFINES_VH

`define MMRB_NUM_REGS      4
`define MMRB_ADDR_W        2
`define MMRB_DATA_W        32
`define MMRB_RESET_VAL     32'h0000_0000
`define MMRB_IDX_REG0      2'h0
`define MMRB_IDX_REG1      2'h1
`define MMRB_IDX_REG2      2'h2
`define MMRB_IDX_REG3      2'h3
`define MMRB_WR_WAIT       3'h4
`define MMRB_RD_WAIT       3'h1
`define MMRB_CNT_W         3

`endif

// File: design/mmrb_bank.v
// memory-mapped register bank: four output registers with read-back
// assumes a single master that holds its request while wait is high
`timescale 1ns/1ps
`default_nettype none
`include "mmrb_defines.vh"

// Summary of operation
// - four registers drive outputs and are readable by the master
// - a write loads only the addressed register, 32 bits wide here
// - read address selects the register returned via a multiplexer
// - multiplexer output captured into read-data register on accepted read
// - fixed mode: writes take four wait states, reads take one
// - pipelined mode: no wait states, read data exactly one cycle later
module mmrb_bank
(
    input  wire                       core_clk,
    input  wire                       rst_b,
    input  wire                       pipelined_mode,
    input  wire [`MMRB_ADDR_W-1:0]    address,
    input  wire                       read,
    input  wire                       write,
    input  wire [`MMRB_DATA_W-1:0]    writedata,
    output reg  [`MMRB_DATA_W-1:0]    readdata,
    output reg                        readdatavalid,
    output wire                       waitrequest,
    output wire [`MMRB_DATA_W-1:0]    out_reg0,
    output wire [`MMRB_DATA_W-1:0]    out_reg1,
    output wire [`MMRB_DATA_W-1:0]    out_reg2,
    output wire [`MMRB_DATA_W-1:0]    out_reg3
);

    // one-hot states of the wait-state sequencer
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg  [1:0]                                 state_r;
    reg  [1:0]                                 state_nxt;
    reg  [`MMRB_CNT_W-1:0]                     cnt_r;
    reg  [`MMRB_CNT_W-1:0]                     cnt_nxt;
    reg  [`MMRB_CNT_W-1:0]                     cnt_load;
    reg                                        kind_wr_r;
    reg                                        kind_wr_nxt;
    reg  [`MMRB_NUM_REGS-1:0]                  wr_sel;
    reg  [`MMRB_DATA_W-1:0]                    mux_out;
    wire [`MMRB_NUM_REGS-1:0]                  wr_load;
    wire [`MMRB_NUM_REGS*`MMRB_DATA_W-1:0]     bank_flat;
    wire                                       wr_req;
    wire                                       rd_req;
    wire                                       req;
    wire                                       in_wait;
    wire                                       cnt_done;
    wire                                       kind_swap;
    wire                                       fire;
    wire                                       wr_fire;
    wire                                       rd_fire;
    genvar                                     g;

    // write wins when both strobes are up, so a read never shadows a store
    assign wr_req = write;
    assign rd_req = read & ~write;
    assign req    = wr_req | rd_req;

    assign in_wait   = (state_r == ST_WAIT);
    assign cnt_done  = (cnt_r == {`MMRB_CNT_W{1'b0}});
    // a master that swaps read for write under wait must not inherit the old count
    assign kind_swap = in_wait & (kind_wr_r != wr_req);

    // fixed mode: the transfer completes once the wait count has run out
    // pipelined mode: every request completes in the cycle it is presented
    assign fire        = req & (pipelined_mode | (in_wait & cnt_done & ~kind_swap));
    assign wr_fire     = fire & wr_req;
    assign rd_fire     = fire & rd_req;
    assign waitrequest = req & ~fire;

    // the cycle that raises the request is already the first wait state
    always @*
    begin
        if (wr_req)
            cnt_load = `MMRB_WR_WAIT - 3'h1;
        else
            cnt_load = `MMRB_RD_WAIT - 3'h1;
    end

    always @*
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        kind_wr_nxt = kind_wr_r;
        case (state_r)
            ST_IDLE:
            begin
                if (req && !pipelined_mode)
                begin
                    state_nxt   = ST_WAIT;
                    cnt_nxt     = cnt_load;
                    kind_wr_nxt = wr_req;
                end
            end
            ST_WAIT:
            begin
                // a request dropped under wait aborts: nothing loaded, nothing returned
                if (!req)
                begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = 3'h0;
                end
                else if (kind_swap)
                begin
                    cnt_nxt     = cnt_load;
                    kind_wr_nxt = wr_req;
                end
                else if (cnt_done)
                begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = 3'h0;
                end
                else
                begin
                    cnt_nxt = cnt_r - 3'h1;
                end
            end
            default:
            begin
                state_nxt   = ST_IDLE;
                cnt_nxt     = 3'h0;
                kind_wr_nxt = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_r   <= ST_IDLE;
            cnt_r     <= 3'h0;
            kind_wr_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            kind_wr_r <= kind_wr_nxt;
        end
    end

    // write decoder: one-hot load enable, only the addressed word may change
    always @*
    begin
        if (address == `MMRB_IDX_REG0)
            wr_sel = 4'h1;
        else if (address == `MMRB_IDX_REG1)
            wr_sel = 4'h2;
        else if (address == `MMRB_IDX_REG2)
            wr_sel = 4'h4;
        else
            wr_sel = 4'h8;
    end

    assign wr_load = wr_sel & {`MMRB_NUM_REGS{wr_fire}};

    // one flop word per register; the flat vector feeds both outputs and read mux
    // a write keeps no byte lanes: the whole word is replaced
    generate
        for (g = 0; g < `MMRB_NUM_REGS; g = g + 1)
        begin : g_word
            reg [`MMRB_DATA_W-1:0] word_r;

            always @(posedge core_clk)
            begin
                if (!rst_b)
                    word_r <= `MMRB_RESET_VAL;
                else if (wr_load[g])
                    word_r <= writedata;
            end

            assign bank_flat[g*`MMRB_DATA_W +: `MMRB_DATA_W] = word_r;
        end
    endgenerate

    // address bits steer the read multiplexer
    always @*
    begin
        if (address == `MMRB_IDX_REG0)
            mux_out = bank_flat[0 +: `MMRB_DATA_W];
        else if (address == `MMRB_IDX_REG1)
            mux_out = bank_flat[`MMRB_DATA_W +: `MMRB_DATA_W];
        else if (address == `MMRB_IDX_REG2)
            mux_out = bank_flat[2*`MMRB_DATA_W +: `MMRB_DATA_W];
        else
            mux_out = bank_flat[3*`MMRB_DATA_W +: `MMRB_DATA_W];
    end

    // registered read adds a stage, buying clock rate for one cycle of latency
    // readdata holds its last value until the next accepted read
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            readdata <= `MMRB_RESET_VAL;
        end
        else if (rd_fire)
        begin
            readdata <= mux_out;
        end
    end

    // valid is a one-cycle strobe, raised by the same edge that accepts the read
    // aborted reads never reach rd_fire, so they raise no strobe
    always @(posedge core_clk)
    begin
        if (!rst_b)
            readdatavalid <= 1'b0;
        else
            readdatavalid <= rd_fire;
    end

    // outputs come straight from the word flops, no decode on the way out
    assign out_reg0 = bank_flat[0 +: `MMRB_DATA_W];
    assign out_reg1 = bank_flat[`MMRB_DATA_W +: `MMRB_DATA_W];
    assign out_reg2 = bank_flat[2*`MMRB_DATA_W +: `MMRB_DATA_W];
    assign out_reg3 = bank_flat[3*`MMRB_DATA_W +: `MMRB_DATA_W];

endmodule // mmrb_bank
`default_nettype wire

// File: tb/mmrb_master.sv
// bus master model for the register bank
// assumes one transfer at a time, driven off the falling edge
`timescale 1ns/1ps
`default_nettype none
module mmrb_master (
    input  wire logic        core_clk,
    input  wire logic [31:0] readdata,
    input  wire logic        readdatavalid,
    input  wire logic        waitrequest,
    output var  logic [1:0]  address = 2'h0,
    output var  logic        read = 1'b0,
    output var  logic        write = 1'b0,
    output var  logic [31:0] writedata = 32'h0
);
    // n counts wait states; idle cycle first so a request never drops and rises in one step
    task automatic xfer(input logic w, input logic [1:0] a, input logic [31:0] d, output int n, output logic [31:0] q);
        @(negedge core_clk);
        {write, read, address, writedata} = {w, !w, a, d};
        n = 0;
        #1;
        while (waitrequest !== 1'b0 && n < 9)
        begin
            @(negedge core_clk);
            #1;
            n++;
        end
        @(negedge core_clk);
        q = readdatavalid ? readdata : 32'hx;
        {write, read, writedata} = {2'b00, ~d};
    endtask
endmodule // mmrb_master
`default_nettype wire

// File: tb/mmrb_monitor.sv
// assertions on the register bank ports
// assumes bind onto mmrb_bank
`timescale 1ns/1ps
`default_nettype none
module mmrb_monitor (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        pipelined_mode,
    input wire logic [1:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        readdatavalid,
    input wire logic        waitrequest,
    input wire logic [31:0] out_reg0
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire wf = write & !waitrequest & address == 2'h0;
    wire rf = read & !write & !waitrequest;
    a_wr_load: assert property (wf |=> out_reg0 == $past(writedata)) else $error("load");
    a_reg_hold: assert property (!wf |=> $stable(out_reg0)) else $error("hold");
    a_rd_mux: assert property (rf && address == 2'h0 |=> readdata == out_reg0) else $error("mux");
    a_rd_valid: assert property (rf |=> readdatavalid) else $error("valid");
    a_wr_wait: assert property (!pipelined_mode && $rose(write) |-> waitrequest [*4] ##1 !waitrequest)
        else $error("wr wait");
    a_rd_wait: assert property (!pipelined_mode && $rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("rd wait");
    a_no_wait: assert property (pipelined_mode && (read || write) |-> !waitrequest) else $error("no wait");
    a_valid_cause: assert property (readdatavalid |-> $past(rf)) else $error("valid cause");
    a_rst_clear: assert property (disable iff (1'b0) !rst_b |=> !out_reg0 && !readdata && !readdatavalid)
        else $error("reset");
    c_wr: cover property (wf);
    c_rd: cover property (rf);
    c_pipe: cover property (pipelined_mode && rf);
    c_wr_fixed: cover property (!pipelined_mode && wf);
endmodule // mmrb_monitor
bind mmrb_bank mmrb_monitor mmrb_monitor_inst (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .pipelined_mode (pipelined_mode),
    .address        (address),
    .read           (read),
    .write          (write),
    .writedata      (writedata),
    .readdata       (readdata),
    .readdatavalid  (readdatavalid),
    .waitrequest    (waitrequest),
    .out_reg0       (out_reg0)
);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the register bank
// assumes bank, master model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic         core_clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         pipelined_mode = 1'b0;
    wire  [31:0]  readdata, writedata, out_reg0, out_reg1, out_reg2, out_reg3;
    wire  [1:0]   address;
    wire          read, write, readdatavalid, waitrequest;
    wire  [127:0] regs = {out_reg3, out_reg2, out_reg1, out_reg0};
    int           n_errors = 0;
    int           tests_run = 0;
    mmrb_bank mmrb_bank_inst (
        .core_clk       (core_clk),
        .rst_b          (rst_b),
        .pipelined_mode (pipelined_mode),
        .address        (address),
        .read           (read),
        .write          (write),
        .writedata      (writedata),
        .readdata       (readdata),
        .readdatavalid  (readdatavalid),
        .waitrequest    (waitrequest),
        .out_reg0       (out_reg0),
        .out_reg1       (out_reg1),
        .out_reg2       (out_reg2),
        .out_reg3       (out_reg3)
    );
    mmrb_master mmrb_master_inst (
        .core_clk       (core_clk),
        .readdata       (readdata),
        .readdatavalid  (readdatavalid),
        .waitrequest    (waitrequest),
        .address        (address),
        .read           (read),
        .write          (write),
        .writedata      (writedata)
    );
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        n_errors += int'(g !== e);
        if (g !== e)
            $display("BAD %s exp %h got %h", what, e, g);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // data tracks mode so a stale value from the first pass cannot match
    task automatic op(input logic w, input int a, input int ew, output logic [31:0] q);
        int n;
        mmrb_master_inst.xfer(w, a[1:0], 32'h5a00_0000 + {pipelined_mode, 8'h00} + a, n, q);
        chk("wait", ew, n);
        if (n > 8)
            finish_test();
    endtask
    task automatic test_reset;
        for (int i = 0; i < 128; i += 32)
            chk("reg", 32'h0, regs[i+:32]);
        chk("rdata", 32'h0, readdata);
        chk("valid", 32'h0, {31'h0, readdatavalid});
        $display("reset test done");
    endtask
    task automatic test_bank(input logic m);
        logic [31:0] q;
        pipelined_mode = m;
        for (int i = 0; i < 4; i++)
            op(1'b1, i, m ? 0 : 4, q);
        for (int i = 0; i < 4; i++)
            chk("reg", 32'h5a00_0000 + {m, 8'h00} + i, regs[i*32+:32]);
        for (int i = 3; i >= 0; i--)
        begin
            op(1'b0, i, m ? 0 : 1, q);
            chk("read", 32'h5a00_0000 + {m, 8'h00} + i, q);
        end
        $display("bank test done");
    endtask
    initial
    begin
        repeat (12) @(negedge core_clk);
        test_reset();
        rst_b = 1'b1;
        test_bank(1'b0);
        test_bank(1'b1);
        rst_b = 1'b0;
        @(negedge core_clk);
        test_reset();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
